/* File: hw/lcg_pkg.sv */
package lcg_pkg;
  // Logical device numbers
  localparam logic [7:0] LDN_FDC = 8'h00;
  localparam logic [7:0] LDN_PP  = 8'h03;
  localparam logic [7:0] LDN_SP1 = 8'h04;
  // Register indices inside a logical device
  localparam logic [7:0] IDX_F0  = 8'hF0;
  localparam logic [7:0] IDX_F1  = 8'hF1;
  localparam logic [7:0] IDX_F2  = 8'hF2;
  localparam logic [7:0] IDX_F3  = 8'hF3;
  localparam logic [7:0] IDX_F4  = 8'hF4;
  localparam logic [7:0] IDX_F5  = 8'hF5;
  // Hard reset values
  localparam logic [7:0] RST_FLOPPY_MODE = 8'h0E;
  localparam logic [7:0] RST_FLOPPY_OPT  = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPE  = 8'hFF;
  localparam logic [7:0] RST_DRIVE_PAR   = 8'h00;
  localparam logic [7:0] RST_PP_MODE     = 8'h3C;
  localparam logic [7:0] RST_PP_MODE_TWO = 8'h00;
  localparam logic [7:0] RST_SP1_MODE    = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  // Writable bits of the masked registers
  localparam logic [7:0] DRV_PAR_MASK    = 8'h5B;
  localparam logic [7:0] SP1_MODE_MASK   = 8'h83;
  // Floppy mode fields
  localparam int FM_ENH_BIT   = 0;
  localparam int FM_NOBURST   = 1;
  localparam int FM_IF_LO     = 2;
  localparam int FM_PUSHPULL  = 6;
  localparam int FM_TRISTATE  = 7;
  // Parallel mode fields and codes
  localparam int PP_MODE_LO   = 0;
  localparam int PP_THR_LO    = 3;
  localparam int PP_PULSE_BIT = 7;
  localparam logic [2:0] PPM_PRINTER = 3'h4;
  localparam logic [2:0] PPM_SPP     = 3'h0;
  localparam logic [2:0] PPM_ECP     = 3'h2;
  localparam logic [2:0] PPM_ECP_E19 = 3'h3;
  localparam logic [2:0] PPM_ECP_E17 = 3'h7;
  localparam logic [1:0] PIN_SHARE_DRV0 = 2'h1;
  // Extended control mode codes that hold the interrupt on
  localparam logic [2:0] ECR_FIFO = 3'h2;
  localparam logic [2:0] ECR_ECP  = 3'h3;
  localparam logic [2:0] ECR_TEST = 3'h6;
  // Serial port 1 mode fields
  localparam int SP_MIDI_BIT  = 0;
  localparam int SP_HS_BIT    = 1;
  localparam int SP_SHARE_BIT = 7;
endpackage : lcg_pkg

/* File: hw/lcg_pin_sync.sv */
`timescale 1ns/100ps
module lcg_pin_sync
  import lcg_pkg::*;
#(
  parameter logic RST_LEVEL = 1'b1
) (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic ce,
  // Pin and clean level
  input  wire logic pin_async,
  output logic      pin_sync_q
);

  typedef struct packed {
    logic s1;  // Metastable stage
    logic s2;  // Second stage
    logic s3;  // Third stage
    logic out; // Accepted level
  } lcg_sync_type;

  lcg_sync_type st_q;
  lcg_sync_type st_d;

  // Accept a change only once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.out = st_q.s3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= {4{RST_LEVEL}};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign pin_sync_q = st_q.out;

endmodule : lcg_pin_sync

/* File: hw/lcg_pin_gate.sv */
`timescale 1ns/100ps
module lcg_pin_gate
  import lcg_pkg::*;
(
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic ce,
  // Request and its permission
  input  wire logic enable,
  input  wire logic level,
  // Pin drive
  output logic      pin_o_q,
  output logic      pin_oe_q
);

  typedef struct packed {
    logic o;  // Driven level
    logic oe; // Drive enable
  } lcg_gate_type;

  lcg_gate_type st_q;
  lcg_gate_type st_d;

  // Float the pin and park the level low when not permitted
  always_comb begin
    st_d.oe = enable;
    st_d.o  = enable & level;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign pin_o_q  = st_q.o;
  assign pin_oe_q = st_q.oe;

endmodule : lcg_pin_gate

/* File: hw/lcg_ldev_cfg.sv */
//Summary of operation
// RL1: Function enable bits float its IRQ, DACK
// RL2: Floppy DMA gate or powerdown floats IRQ, DACK
// RL3: Serial aux output two low floats IRQ
// RL4: Standard/enhanced parallel IRQ follows IRQ gate
// RL5: ECP: DMA follows gate; IRQ on some codes
// RL6: Registers reset only on hard reset
// RL7: Floppy mode bits: enhanced, non-burst DMA
// RL8: Floppy mode bits 3:2 select host interface
// RL9: Floppy output type and tri-state bits
// RL10: Drive type store resets to FF
// RL11: Index F3 reads zero, read only
// RL12: Drive params: type, rate, precomp; rest zero
// RL13: Parallel mode bits 2:0 select port mode
// RL14: Parallel bits 6:3 hold FIFO threshold
// RL15: Parallel bit 7 selects interrupt form
// RL16: Mode two bits 1:0 share pins
// RL17: Serial mode: MIDI, high speed, reserved zero
// RL18: Software assigns one line before sharing
// RL19: Share with two lines drives both
// RL20: Unused IRQ/DMA pins stay tri-stated
// RL21: Shared line carries OR of both UARTs
`timescale 1ns/100ps
module lcg_ldev_cfg
  import lcg_pkg::*;
(
  // Clock, hard reset, clock enable
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Configuration access port
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_ldn,
  input  wire logic [7:0] cfg_index,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata_q,
  // Floppy function
  input  wire logic       fdc_active,
  input  wire logic       floppy_dma_gate,
  input  wire logic       fdc_powerdown,
  input  wire logic       fdc_irq_req,
  input  wire logic       fdc_drq_req,
  input  wire logic       fdc_dack_pin_n,
  output logic            fdc_irq_o,
  output logic            fdc_irq_oe,
  output logic            fdc_drq_o,
  output logic            fdc_drq_oe,
  output logic            fdc_dack_core_q,
  // Serial functions
  input  wire logic       uart1_active,
  input  wire logic       uart1_aux_output_two,
  input  wire logic       uart1_irq_req,
  input  wire logic       uart1_irq_assigned,
  input  wire logic       uart2_active,
  input  wire logic       uart2_aux_output_two,
  input  wire logic       uart2_irq_req,
  input  wire logic       uart2_irq_assigned,
  output logic            uart1_irq_o,
  output logic            uart1_irq_oe,
  output logic            uart2_irq_o,
  output logic            uart2_irq_oe,
  // Parallel function
  input  wire logic       pp_active,
  input  wire logic       parallel_irq_gate,
  input  wire logic       ecp_dma_gate,
  input  wire logic [2:0] ecp_mode,
  input  wire logic       pp_irq_req,
  input  wire logic       pp_drq_req,
  output logic            pp_irq_o_q,
  output logic            pp_irq_oe_q,
  output logic            pp_drq_o,
  output logic            pp_drq_oe,
  // Register contents toward the functions
  output logic      [7:0] floppy_mode_cfg_q,
  output logic      [7:0] floppy_option_cfg_q,
  output logic      [7:0] floppy_drive_type_store_q,
  output logic      [7:0] drive_zero_params_q,
  output logic      [7:0] drive_one_params_q,
  output logic      [7:0] parallel_mode_cfg_q,
  output logic      [7:0] parallel_mode_cfg_two_q,
  output logic      [7:0] serial_one_mode_cfg_q,
  output logic            drive_zero_on_shared_pins_q
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] fmode;   // Floppy mode
    logic [7:0] fopt;    // Floppy option
    logic [7:0] ftype;   // Drive type store
    logic [7:0] drv0;    // Drive zero params
    logic [7:0] drv1;    // Drive one params
    logic [7:0] pmode;   // Parallel mode
    logic [7:0] pmode2;  // Parallel mode two
    logic [7:0] smode;   // Serial one mode
    logic [7:0] rdata;   // Read data
    logic       pp_prev; // Last parallel request
    logic       pirq_o;  // Parallel IRQ level
    logic       pirq_oe; // Parallel IRQ enable
    logic       dack;    // Gated acknowledge
    logic       drv0sh;  // Drive zero on shared pins
  } lcg_cfg_type;

  lcg_cfg_type st_q;
  lcg_cfg_type st_d;

  logic       dack_n_sync; // Clean acknowledge pin
  logic       fdc_ok;      // Floppy may drive
  logic       u1_ok;       // UART 1 permitted
  logic       u2_ok;       // UART 2 permitted
  logic       u1_gated;    // UART 1 request after gating
  logic       u2_gated;    // UART 2 request after gating
  logic       share;       // Shared interrupt selected
  logic       u1_en;       // UART 1 pin enable
  logic       u2_en;       // UART 2 pin enable
  logic [2:0] pp_mode;     // Configured parallel mode
  logic       pp_ecp_cfg;  // One of the ECP modes
  logic       ecr_on;      // ECR code holds IRQ on
  logic       pp_irq_en;   // Parallel IRQ permitted
  logic       pp_pulse;    // Pulsed interrupt form
  logic       pp_drq_en;   // Parallel DMA permitted
  logic       hit_fdc;     // Access to floppy device
  logic       hit_pp;      // Access to parallel device
  logic       hit_sp1;     // Access to serial one

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge pin crossing

  lcg_pin_sync #(
    .RST_LEVEL (1'b1)
  ) u_dack_sync (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .ce         (ce),
    .pin_async  (fdc_dack_pin_n),
    .pin_sync_q (dack_n_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Permission terms

  // Floppy drives only while active, gated and powered
  assign fdc_ok = fdc_active & floppy_dma_gate & ~fdc_powerdown; // RL1 RL2

  // Serial needs aux output two high
  assign u1_ok    = uart1_active & uart1_aux_output_two; // RL3
  assign u2_ok    = uart2_active & uart2_aux_output_two; // RL3
  assign u1_gated = u1_ok & uart1_irq_req;
  assign u2_gated = u2_ok & uart2_irq_req;
  assign share    = st_q.smode[SP_SHARE_BIT];

  // An unassigned line never drives; a shared line carries either UART
  assign u1_en = uart1_irq_assigned & (u1_ok | (share & u2_ok)); // RL19 RL20
  assign u2_en = uart2_irq_assigned & (u2_ok | (share & u1_ok)); // RL19 RL20

  // Parallel mode decode
  assign pp_mode    = st_q.pmode[PP_MODE_LO +: 3]; // RL13
  assign pp_ecp_cfg = (pp_mode == PPM_ECP) | (pp_mode == PPM_ECP_E19) |
                      (pp_mode == PPM_ECP_E17);
  assign ecr_on     = (ecp_mode == ECR_FIFO) | (ecp_mode == ECR_ECP) |
                      (ecp_mode == ECR_TEST);

  // IRQ held on for some ECR codes, else follows IRQ gate
  assign pp_irq_en = pp_active & ((pp_ecp_cfg & ecr_on) | parallel_irq_gate); // RL4 RL5

  // Pulse form is meaningless in printer and standard modes
  assign pp_pulse = st_q.pmode[PP_PULSE_BIT] & (pp_mode != PPM_PRINTER) &
                    (pp_mode != PPM_SPP); // RL15

  // DMA request exists only in ECP modes and follows its gate
  assign pp_drq_en = pp_active & pp_ecp_cfg & ecp_dma_gate; // RL5 RL20

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Floppy interrupt
  lcg_pin_gate u_fdc_irq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (fdc_ok),
    .level    (fdc_irq_req),
    .pin_o_q  (fdc_irq_o),
    .pin_oe_q (fdc_irq_oe)
  );

  // Floppy DMA request, ignored while gated off
  lcg_pin_gate u_fdc_drq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (fdc_ok),
    .level    (fdc_drq_req),
    .pin_o_q  (fdc_drq_o),
    .pin_oe_q (fdc_drq_oe)
  );

  // UART 1 line, OR of both while shared
  lcg_pin_gate u_u1_irq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (u1_en),
    .level    (u1_gated | (share & u2_gated)), // RL21
    .pin_o_q  (uart1_irq_o),
    .pin_oe_q (uart1_irq_oe)
  );

  // UART 2 line, OR of both while shared
  lcg_pin_gate u_u2_irq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (u2_en),
    .level    (u2_gated | (share & u1_gated)), // RL21
    .pin_o_q  (uart2_irq_o),
    .pin_oe_q (uart2_irq_oe)
  );

  // Parallel DMA request
  lcg_pin_gate u_pp_drq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (pp_drq_en),
    .level    (pp_drq_req),
    .pin_o_q  (pp_drq_o),
    .pin_oe_q (pp_drq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file and parallel interrupt form

  assign hit_fdc = (cfg_ldn == LDN_FDC);
  assign hit_pp  = (cfg_ldn == LDN_PP);
  assign hit_sp1 = (cfg_ldn == LDN_SP1);

  // Next state: writes, read mux, gated pins
  always_comb begin
    st_d = st_q;
    // Configuration writes
    if (cfg_wr) begin
      if (hit_fdc) begin
        unique case (cfg_index)
          IDX_F0: st_d.fmode = cfg_wdata; // RL7 RL8 RL9
          IDX_F1: st_d.fopt  = cfg_wdata;
          IDX_F2: st_d.ftype = cfg_wdata; // RL10
          IDX_F4: st_d.drv0  = cfg_wdata & DRV_PAR_MASK; // RL12
          IDX_F5: st_d.drv1  = cfg_wdata & DRV_PAR_MASK; // RL12
          default: ; // F3 and others hold nothing RL11
        endcase
      end else if (hit_pp) begin
        unique case (cfg_index)
          IDX_F0: st_d.pmode  = cfg_wdata; // RL13 RL14 RL15
          IDX_F1: st_d.pmode2 = cfg_wdata; // RL16
          default: ;
        endcase
      end else if (hit_sp1 && cfg_index == IDX_F0) begin
        // Reserved bits never stored
        st_d.smode = cfg_wdata & SP1_MODE_MASK; // RL17
      end
    end
    // Read data, zero for reserved or unmapped indices
    if (cfg_rd) begin
      st_d.rdata = READ_ZERO; // RL11
      if (hit_fdc) begin
        unique case (cfg_index)
          IDX_F0: st_d.rdata = st_q.fmode;
          IDX_F1: st_d.rdata = st_q.fopt;
          IDX_F2: st_d.rdata = st_q.ftype;
          IDX_F4: st_d.rdata = st_q.drv0;
          IDX_F5: st_d.rdata = st_q.drv1;
          default: st_d.rdata = READ_ZERO; // RL11
        endcase
      end else if (hit_pp) begin
        unique case (cfg_index)
          IDX_F0: st_d.rdata = st_q.pmode;
          IDX_F1: st_d.rdata = st_q.pmode2;
          default: st_d.rdata = READ_ZERO;
        endcase
      end else if (hit_sp1 && cfg_index == IDX_F0) begin
        st_d.rdata = st_q.smode;
      end
    end
    // Pin share decode toward the floppy pins
    st_d.drv0sh = (st_q.pmode2[1:0] == PIN_SHARE_DRV0); // RL16
    // Floppy acknowledge reaches the core only while permitted
    st_d.dack = fdc_ok & ~dack_n_sync; // RL1 RL2
    // Parallel interrupt: one low pulse per rising request, else level
    st_d.pp_prev = pp_irq_req;
    if (!pp_irq_en) begin
      st_d.pirq_oe = 1'b0; // RL4
      st_d.pirq_o  = 1'b0;
    end else if (pp_pulse) begin
      st_d.pirq_oe = pp_irq_req & ~st_q.pp_prev; // RL15
      st_d.pirq_o  = 1'b0;
    end else begin
      st_d.pirq_oe = 1'b1; // RL5
      st_d.pirq_o  = pp_irq_req;
    end
  end

  // Hard reset only; soft resets do not reach this block
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q        <= '0; // RL6
      st_q.fmode  <= RST_FLOPPY_MODE;
      st_q.fopt   <= RST_FLOPPY_OPT;
      st_q.ftype  <= RST_DRIVE_TYPE; // RL10
      st_q.drv0   <= RST_DRIVE_PAR;
      st_q.drv1   <= RST_DRIVE_PAR;
      st_q.pmode  <= RST_PP_MODE; // RL14
      st_q.pmode2 <= RST_PP_MODE_TWO;
      st_q.smode  <= RST_SP1_MODE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Register outputs
  assign cfg_rdata_q                 = st_q.rdata;
  assign floppy_mode_cfg_q           = st_q.fmode;
  assign floppy_option_cfg_q         = st_q.fopt;
  assign floppy_drive_type_store_q   = st_q.ftype;
  assign drive_zero_params_q         = st_q.drv0;
  assign drive_one_params_q          = st_q.drv1;
  assign parallel_mode_cfg_q         = st_q.pmode;
  assign parallel_mode_cfg_two_q     = st_q.pmode2;
  assign serial_one_mode_cfg_q       = st_q.smode;
  assign drive_zero_on_shared_pins_q = st_q.drv0sh;
  assign fdc_dack_core_q             = st_q.dack;
  assign pp_irq_o_q                  = st_q.pirq_o;
  assign pp_irq_oe_q                 = st_q.pirq_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_pp_rise;
    ce && pp_irq_en && pp_pulse && pp_irq_req && !st_q.pp_prev;
  endsequence

  sequence s_low_pulse;
    pp_irq_oe_q && !pp_irq_o_q;
  endsequence

  a_f3_reads_zero: assert property ( // RL11
    ce && cfg_rd && hit_fdc && cfg_index == IDX_F3 |=> cfg_rdata_q == READ_ZERO
  ) else $error("index F3 did not read zero");

  a_drive_rsvd_zero: assert property ( // RL12
    (drive_zero_params_q & ~DRV_PAR_MASK) == READ_ZERO &&
    (drive_one_params_q & ~DRV_PAR_MASK) == READ_ZERO
  ) else $error("drive params reserved bit set");

  a_type_store_write: assert property ( // RL10
    ce && cfg_wr && hit_fdc && cfg_index == IDX_F2 |=>
      floppy_drive_type_store_q == $past(cfg_wdata)
  ) else $error("drive type store not written");

  a_fdc_gate_float: assert property ( // RL2
    ce && (!floppy_dma_gate || fdc_powerdown) |=> !fdc_irq_oe && !fdc_drq_oe &&
      !fdc_dack_core_q
  ) else $error("floppy drives while gated off");

  a_uart_aux_float: assert property ( // RL3
    ce && !uart1_aux_output_two && !(share && u2_ok) |=> !uart1_irq_oe
  ) else $error("uart1 drives with aux output two low");

  a_share_both_lines: assert property ( // RL19
    ce && share && uart1_irq_assigned && uart2_irq_assigned && u2_gated |=>
      uart1_irq_o && uart2_irq_o && uart1_irq_oe && uart2_irq_oe
  ) else $error("shared interrupt not on both lines");

  a_unassigned_float: assert property ( // RL20
    ce && !uart2_irq_assigned |=> !uart2_irq_oe
  ) else $error("unassigned uart2 line driven");

  a_pp_gate_float: assert property ( // RL4
    ce && !parallel_irq_gate && !(pp_ecp_cfg && ecr_on) |=> !pp_irq_oe_q
  ) else $error("parallel irq driven with gate low");

  a_ecp_drq_follow: assert property ( // RL5
    ce && pp_active && pp_ecp_cfg |=> pp_drq_oe == $past(ecp_dma_gate)
  ) else $error("ecp dma request not following gate");

  a_pp_pulse_low: assert property ( // RL15
    s_pp_rise |=> s_low_pulse
  ) else $error("parallel pulse not driven low");

endmodule : lcg_ldev_cfg

/* File: verif/lcg_host_model.sv */
`timescale 1ns/100ps
module lcg_host_model
  import lcg_pkg::*;
#(
  parameter int ACK_DELAY = 2  // Cycles a request waits for its acknowledge
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Request pin from the device
  input  wire logic drq_o,
  input  wire logic drq_oe,
  // Acknowledge pin back to the device
  output logic      dack_pin_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // Controller state: wait counter and acknowledge level
  typedef struct packed {
    logic [3:0] cnt;
    logic       ack;
  } lcg_host_type;
  lcg_host_type st_q;  // Registered state
  lcg_host_type st_d;  // Next state

  // Only a driven high request is honoured; a floated pin is no request
  always_comb begin
    st_d = st_q;
    if (!(drq_oe && drq_o)) begin
      st_d = '0;  // Released request drops the acknowledge at once
    end else if (st_q.cnt != 4'(ACK_DELAY)) begin
      st_d.cnt = st_q.cnt + 4'h1;  // Slow arbiter: let the request wait
    end else begin
      st_d.ack = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Active-low pin, driven high while no acknowledge is given
  assign dack_pin_n = !st_q.ack;
endmodule : lcg_host_model

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import lcg_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic sys_clk, reset, ce, cfg_wr, cfg_rd;
  logic [7:0] cfg_ldn, cfg_index, cfg_wdata, cfg_rdata_q;
  logic fdc_active, floppy_dma_gate, fdc_powerdown, fdc_irq_req, fdc_drq_req, fdc_dack_pin_n;
  logic fdc_irq_o, fdc_irq_oe, fdc_drq_o, fdc_drq_oe, fdc_dack_core_q;
  logic uart1_active, uart1_aux_output_two, uart1_irq_req, uart1_irq_assigned;
  logic uart2_active, uart2_aux_output_two, uart2_irq_req, uart2_irq_assigned;
  logic uart1_irq_o, uart1_irq_oe, uart2_irq_o, uart2_irq_oe;
  logic pp_active, parallel_irq_gate, ecp_dma_gate, pp_irq_req, pp_drq_req;
  logic [2:0] ecp_mode;
  logic pp_irq_o_q, pp_irq_oe_q, pp_drq_o, pp_drq_oe, drive_zero_on_shared_pins_q;
  logic [7:0] floppy_mode_cfg_q, floppy_option_cfg_q, floppy_drive_type_store_q;
  logic [7:0] drive_zero_params_q, drive_one_params_q, parallel_mode_cfg_q;
  logic [7:0] parallel_mode_cfg_two_q, serial_one_mode_cfg_q;
  int         errors;        // Mismatch count
  int         total_checks;  // Comparison count
  int         i;             // Loop index
  logic       e;             // Expected permission
  logic [7:0] n;             // Pulse cycle count

  ////////////////////////////////////////////////////////////////////////////////
  // Design and host side
  lcg_ldev_cfg lcg_ldev_cfg_inst (
    .sys_clk, .reset, .ce, .cfg_wr, .cfg_rd, .cfg_ldn, .cfg_index, .cfg_wdata, .cfg_rdata_q,
    .fdc_active, .floppy_dma_gate, .fdc_powerdown, .fdc_irq_req, .fdc_drq_req,
    .fdc_dack_pin_n, .fdc_irq_o, .fdc_irq_oe, .fdc_drq_o, .fdc_drq_oe, .fdc_dack_core_q,
    .uart1_active, .uart1_aux_output_two, .uart1_irq_req, .uart1_irq_assigned,
    .uart2_active, .uart2_aux_output_two, .uart2_irq_req, .uart2_irq_assigned,
    .uart1_irq_o, .uart1_irq_oe, .uart2_irq_o, .uart2_irq_oe,
    .pp_active, .parallel_irq_gate, .ecp_dma_gate, .ecp_mode, .pp_irq_req, .pp_drq_req,
    .pp_irq_o_q, .pp_irq_oe_q, .pp_drq_o, .pp_drq_oe,
    .floppy_mode_cfg_q, .floppy_option_cfg_q, .floppy_drive_type_store_q,
    .drive_zero_params_q, .drive_one_params_q, .parallel_mode_cfg_q,
    .parallel_mode_cfg_two_q, .serial_one_mode_cfg_q, .drive_zero_on_shared_pins_q);

  lcg_host_model lcg_host_model_inst (
    .sys_clk(sys_clk), .reset(reset), .drq_o(fdc_drq_o), .drq_oe(fdc_drq_oe),
    .dack_pin_n(fdc_dack_pin_n));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and finish
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Strobe tasks end one idle cycle after the access
  task automatic wr(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] d);
    {cfg_wr, cfg_ldn, cfg_index, cfg_wdata} = {1'b1, ldn, idx, d};
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] exp);
    {cfg_rd, cfg_ldn, cfg_index} = {1'b1, ldn, idx};
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    @(negedge sys_clk);
    chk("cfg_rdata_q", exp, cfg_rdata_q);
  endtask : rd

  // Pin pair check: oe in bit 1, level in bit 0
  task automatic pin(input string nm, input logic [1:0] exp, input logic [1:0] got);
    chk(nm, 8'(exp), 8'(got));
  endtask : pin

  // Bounded wait for the gated acknowledge; running out ends the run
  task automatic wait_dack(input logic exp);
    int k;
    for (k = 0; k < 20 && fdc_dack_core_q !== exp; k++) @(negedge sys_clk);
    chk("fdc_dack_core_q", 8'(exp), 8'(fdc_dack_core_q));
    if (fdc_dack_core_q !== exp) end_sim;
  endtask : wait_dack

  // Hard reset for two cycles
  task automatic hard_reset;
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
  endtask : hard_reset

  // Every register against its hard reset value, plus an unmapped device
  task automatic defaults;
    rd(LDN_FDC, IDX_F0, 8'h0E);
    rd(LDN_FDC, IDX_F1, 8'h00);
    rd(LDN_FDC, IDX_F2, 8'hFF);
    rd(LDN_FDC, IDX_F3, 8'h00);
    rd(LDN_FDC, IDX_F4, 8'h00);
    rd(LDN_FDC, IDX_F5, 8'h00);
    rd(LDN_PP, IDX_F0, 8'h3C);
    rd(LDN_PP, IDX_F1, 8'h00);
    rd(LDN_SP1, IDX_F0, 8'h00);
    rd(8'h05, IDX_F0, 8'h00);
  endtask : defaults

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {errors, total_checks} = '0;
    {ce, cfg_wr, cfg_rd, cfg_ldn, cfg_index, cfg_wdata} = {1'b1, 26'h0};
    {fdc_active, floppy_dma_gate, fdc_powerdown, fdc_irq_req, fdc_drq_req} = '0;
    {uart1_active, uart1_aux_output_two, uart1_irq_req, uart1_irq_assigned} = '0;
    {uart2_active, uart2_aux_output_two, uart2_irq_req, uart2_irq_assigned} = '0;
    {pp_active, parallel_irq_gate, ecp_dma_gate, ecp_mode, pp_irq_req, pp_drq_req} = '0;
    hard_reset;
    defaults;
    // Storage, masks and the read-only hole
    wr(LDN_FDC, IDX_F2, 8'hA5);
    rd(LDN_FDC, IDX_F2, 8'hA5);
    wr(LDN_FDC, IDX_F3, 8'hFF);
    rd(LDN_FDC, IDX_F3, 8'h00);
    wr(LDN_FDC, IDX_F4, 8'hFF);
    rd(LDN_FDC, IDX_F4, 8'h5B);
    wr(LDN_FDC, IDX_F5, 8'hFF);
    rd(LDN_FDC, IDX_F5, 8'h5B);
    wr(LDN_SP1, IDX_F0, 8'hFF);
    rd(LDN_SP1, IDX_F0, 8'h83);
    // Every interface code with output type and tri-state set
    for (i = 0; i < 4; i++) begin
      wr(LDN_FDC, IDX_F0, {4'hC, 2'(i), 2'b01});
      chk("floppy_mode_cfg_q", {4'hC, 2'(i), 2'b01}, floppy_mode_cfg_q);
    end
    // Every parallel mode code, threshold kept
    for (i = 0; i < 8; i++) begin
      wr(LDN_PP, IDX_F0, {5'h0F, 3'(i)});
      rd(LDN_PP, IDX_F0, {5'h0F, 3'(i)});
    end
    wr(LDN_PP, IDX_F1, 8'h01);
    @(negedge sys_clk);
    chk("shared_pins", 8'h01, 8'(drive_zero_on_shared_pins_q));
    // Hard reset in mid-run restores every default
    hard_reset;
    defaults;
    // Floppy permission: active, gate and power-down in all combinations
    {fdc_irq_req, fdc_drq_req} = 2'b11;
    for (i = 0; i < 8; i++) begin
      {fdc_active, floppy_dma_gate, fdc_powerdown} = 3'(i);
      e = fdc_active & floppy_dma_gate & !fdc_powerdown;
      @(negedge sys_clk);
      pin("fdc_irq", {e, e}, {fdc_irq_oe, fdc_irq_o});
      pin("fdc_drq", {e, e}, {fdc_drq_oe, fdc_drq_o});
    end
    {fdc_active, floppy_dma_gate, fdc_powerdown} = 3'b110;
    wait_dack(1'b1);
    floppy_dma_gate = 1'b0;
    wait_dack(1'b0);
    // Serial: one line assigned, the other unassigned, then shared, then both lines assigned
    {uart1_active, uart1_aux_output_two, uart1_irq_req, uart1_irq_assigned} = 4'hF;
    {uart2_active, uart2_aux_output_two} = 2'b11;
    @(negedge sys_clk);
    pin("uart1_irq", 2'b11, {uart1_irq_oe, uart1_irq_o});
    pin("uart2_irq", 2'b00, {uart2_irq_oe, uart2_irq_o});
    uart1_aux_output_two = 1'b0;
    @(negedge sys_clk);
    pin("uart1_irq", 2'b00, {uart1_irq_oe, uart1_irq_o});
    {uart1_aux_output_two, uart1_irq_req, uart2_irq_req} = 3'b101;
    @(negedge sys_clk);
    pin("uart1_irq", 2'b10, {uart1_irq_oe, uart1_irq_o});
    wr(LDN_SP1, IDX_F0, 8'h80);
    @(negedge sys_clk);
    pin("uart1_irq", 2'b11, {uart1_irq_oe, uart1_irq_o});
    uart2_irq_assigned = 1'b1;
    @(negedge sys_clk);
    pin("uart1_irq", 2'b11, {uart1_irq_oe, uart1_irq_o});
    pin("uart2_irq", 2'b11, {uart2_irq_oe, uart2_irq_o});
    // Parallel in printer mode: gate decides, no DMA drive
    {pp_active, parallel_irq_gate, pp_irq_req, ecp_dma_gate, pp_drq_req} = 5'h1F;
    @(negedge sys_clk);
    pin("pp_irq", 2'b11, {pp_irq_oe_q, pp_irq_o_q});
    pin("pp_drq", 2'b00, {pp_drq_oe, pp_drq_o});
    parallel_irq_gate = 1'b0;
    @(negedge sys_clk);
    pin("pp_irq", 2'b00, {pp_irq_oe_q, pp_irq_o_q});
    // Extended mode: some control codes hold the interrupt on
    wr(LDN_PP, IDX_F0, 8'h3A);
    for (i = 0; i < 8; i++) begin
      ecp_mode = 3'(i);
      e = (i == 2) || (i == 3) || (i == 6);
      @(negedge sys_clk);
      pin("pp_irq", {e, e}, {pp_irq_oe_q, pp_irq_o_q});
      pin("pp_drq", 2'b11, {pp_drq_oe, pp_drq_o});
    end
    ecp_dma_gate = 1'b0;
    @(negedge sys_clk);
    pin("pp_drq", 2'b00, {pp_drq_oe, pp_drq_o});
    // Pulsed form: one low cycle per rising request, then released
    wr(LDN_PP, IDX_F0, 8'hBA);
    {ecp_mode, pp_irq_req, n} = {3'h2, 1'b0, 8'h00};
    repeat (2) @(negedge sys_clk);
    pp_irq_req = 1'b1;
    repeat (4) begin
      @(negedge sys_clk);
      if (pp_irq_oe_q === 1'b1) begin
        n = n + ((pp_irq_o_q === 1'b0) ? 8'h01 : 8'h10);
      end
    end
    chk("pp_pulse", 8'h01, n);
    end_sim;
  end
endmodule : testbench
